/* File: rtl/pgbs_regs.vh */
// Purpose: Constants for the generic message block skipper.
// Assumes: Byte stream, header packed most significant bit first.
// Notes: No software registers; all steering is by ports.
// How it works
// - Types five to fifteen are generic blocks.
// - Reserved bits accepted with any value.
// - Nine-bit body size read from header.
// - Block length is body size plus five.
// - Body limit 343 on 4K, 511 on 8K.
// - Last three octets hold CRC-24-D over block.
// - Unsupported type blocks are discarded whole.
`ifndef PGBS_REGS_VH
`define PGBS_REGS_VH
`define PGBS_TYPE_MIN 4'h5
`define PGBS_TYPE_MAX 4'hF
`define PGBS_TYPE_HI 7
`define PGBS_TYPE_LO 4
`define PGBS_RSV_HI 3
`define PGBS_RSV_LO 1
`define PGBS_SIZE_MSB 0
`define PGBS_EXTRA 10'h005
`define PGBS_MAX_4K 9'h157
`define PGBS_CRC_LEN 10'h003
`define PGBS_CRC_POLY 24'h864CFB
`define PGBS_CRC_INIT 24'h000000
`define PGBS_ST_HDR0 2'h0
`define PGBS_ST_HDR1 2'h1
`define PGBS_ST_BODY 2'h2
`define PGBS_ST_CRC 2'h3
`define PGBS_CNT_ZERO 10'h000
`define PGBS_CNT_ONE 10'h001
`define PGBS_SIZE_ZERO 9'h000
`define PGBS_BYTE_ZERO 8'h00
`define PGBS_RSV_ZERO 3'h0
`define PGBS_TYPE_ZERO 4'h0
`define PGBS_CRC_ZERO 24'h000000
`endif

/* File: rtl/pgbs_skipper.v */
// Purpose: Parses generic message blocks and skips unsupported ones.
// Assumes: Bytes come one per cycle from logic on the same clock.
// Notes: Supported types are chosen by a 16-bit mask input.
`timescale 1ns/1ps
`include "pgbs_regs.vh"
module pgbs_skipper
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Byte stream in
  input wire byte_valid_i,
  input wire [7:0] byte_data_i,
  input wire blk_start_i,
  // Configuration
  input wire fft_4k_i,
  input wire [15:0] supported_mask_i,
  // Forwarded bytes of supported blocks
  output reg fwd_valid_o,
  output reg [7:0] fwd_data_o,
  // Block status
  output reg blk_done_o,
  output reg blk_generic_o,
  output reg blk_skipped_o,
  output reg blk_crc_ok_o,
  output reg blk_size_err_o,
  output reg [3:0] blk_type_o,
  output reg [2:0] reserved_bits_o,
  output reg [8:0] body_size_o,
  output wire busy_o
);
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [9:0] count_reg;
  reg [9:0] count_next;
  reg [23:0] crc_reg;
  reg [23:0] rx_crc_reg;
  reg [7:0] hdr0_reg;
  reg skip_reg;
  reg [23:0] crc_step;
  integer i;
  wire [1:0] cur_state;
  wire at_hdr0;
  wire [3:0] cur_type;
  wire type_generic;
  wire type_supported;
  wire [8:0] size_now;
  wire last_byte;
  wire [23:0] crc_final;

  // A resync strobe makes this octet header octet 0, whatever the walk believed.
  assign cur_state = blk_start_i ? `PGBS_ST_HDR0 : state_reg;
  assign at_hdr0 = (cur_state == `PGBS_ST_HDR0);
  assign cur_type = hdr0_reg[`PGBS_TYPE_HI:`PGBS_TYPE_LO];
  // Any type from five up, a 4-bit field cannot exceed fifteen.
  assign type_generic = (cur_type >= `PGBS_TYPE_MIN);
  assign type_supported = supported_mask_i[cur_type];
  assign size_now = {hdr0_reg[`PGBS_SIZE_MSB], byte_data_i};
  assign last_byte = (cur_state == `PGBS_ST_CRC) && (count_reg == `PGBS_CNT_ONE);
  assign crc_final = {rx_crc_reg[15:0], byte_data_i};
  assign busy_o = (state_reg != `PGBS_ST_HDR0);

  // Header octet 0 starts from the seed, so a finished block's value never leaks in.
  always @*
  begin
    crc_step = at_hdr0 ? `PGBS_CRC_INIT : crc_reg;
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (crc_step[23] ^ byte_data_i[i])
        crc_step = {crc_step[22:0], 1'b0} ^ `PGBS_CRC_POLY;
      else
        crc_step = {crc_step[22:0], 1'b0};
    end
  end

  always @*
  begin
    state_next = state_reg;
    if (byte_valid_i)
    begin
      case (cur_state)
        `PGBS_ST_HDR0:
          state_next = `PGBS_ST_HDR1;
        `PGBS_ST_HDR1:
          state_next = (size_now == `PGBS_SIZE_ZERO) ? `PGBS_ST_CRC : `PGBS_ST_BODY;
        `PGBS_ST_BODY:
          if (count_reg == `PGBS_CNT_ONE)
            state_next = `PGBS_ST_CRC;
        `PGBS_ST_CRC:
          if (count_reg == `PGBS_CNT_ONE)
            state_next = `PGBS_ST_HDR0;
        default:
          state_next = `PGBS_ST_HDR0;
      endcase
    end
  end

  always @*
  begin
    count_next = count_reg;
    case (cur_state)
      `PGBS_ST_HDR1:
        // Body octets left; two header octets are gone, and the check field is counted once the body ends.
        count_next = (size_now == `PGBS_SIZE_ZERO) ? `PGBS_CRC_LEN : {1'b0, size_now};
      `PGBS_ST_BODY:
        count_next = (count_reg == `PGBS_CNT_ONE) ? `PGBS_CRC_LEN : count_reg - `PGBS_CNT_ONE;
      `PGBS_ST_CRC:
        count_next = count_reg - `PGBS_CNT_ONE;
      default:
        count_next = count_reg;
    endcase
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= `PGBS_ST_HDR0;
      count_reg <= `PGBS_CNT_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      if (byte_valid_i)
        count_reg <= count_next;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      crc_reg <= `PGBS_CRC_INIT;
      rx_crc_reg <= `PGBS_CRC_ZERO;
    end
    else if (byte_valid_i)
    begin
      // Check octets are collected, never folded into the running value.
      if (cur_state == `PGBS_ST_CRC)
        rx_crc_reg <= crc_final;
      else
        crc_reg <= crc_step;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hdr0_reg <= `PGBS_BYTE_ZERO;
      skip_reg <= 1'b0;
    end
    else if (byte_valid_i)
    begin
      if (at_hdr0)
      begin
        hdr0_reg <= byte_data_i;
        skip_reg <= 1'b0;
      end
      else if (cur_state == `PGBS_ST_HDR1)
        skip_reg <= !type_supported;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reserved_bits_o <= `PGBS_RSV_ZERO;
      blk_type_o <= `PGBS_TYPE_ZERO;
      body_size_o <= `PGBS_SIZE_ZERO;
      blk_generic_o <= 1'b0;
      blk_size_err_o <= 1'b0;
    end
    else if (byte_valid_i && cur_state == `PGBS_ST_HDR1)
    begin
      // Reserved bits are passed on, never checked.
      reserved_bits_o <= hdr0_reg[`PGBS_RSV_HI:`PGBS_RSV_LO];
      blk_type_o <= cur_type;
      body_size_o <= size_now;
      blk_generic_o <= type_generic;
      // Oversize on 4K is flagged, yet the block is still walked to keep framing.
      blk_size_err_o <= fft_4k_i && (size_now > `PGBS_MAX_4K);
    end
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fwd_valid_o <= 1'b0;
      fwd_data_o <= `PGBS_BYTE_ZERO;
    end
    else
    begin
      fwd_valid_o <= 1'b0;
      if (byte_valid_i)
      begin
        fwd_data_o <= byte_data_i;
        // Discarded blocks never reach the forward port.
        if (cur_state == `PGBS_ST_HDR1)
          fwd_valid_o <= type_supported;
        else if (!at_hdr0)
          fwd_valid_o <= !skip_reg;
      end
    end
  end

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blk_done_o <= 1'b0;
      blk_skipped_o <= 1'b0;
      blk_crc_ok_o <= 1'b0;
    end
    else
    begin
      blk_done_o <= 1'b0;
      if (byte_valid_i && last_byte)
      begin
        blk_done_o <= 1'b1;
        blk_skipped_o <= skip_reg;
        blk_crc_ok_o <= (crc_final == crc_reg);
      end
    end
  end
endmodule

/* File: sim/pgbs_props.sv */
// Purpose: Port checker for the skipper.
// Assumes: Mask and 4K flag stay put within a block.
// Notes: Status fields are judged at the done pulse.
`timescale 1ns/1ps
module pgbs_props
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Stream and configuration
  input wire byte_valid_i,
  input wire [7:0] byte_data_i,
  input wire blk_start_i,
  input wire fft_4k_i,
  input wire [15:0] supported_mask_i,
  // Forward port and status
  input wire fwd_valid_o,
  input wire [7:0] fwd_data_o,
  input wire blk_done_o,
  input wire blk_generic_o,
  input wire blk_skipped_o,
  input wire blk_size_err_o,
  input wire [3:0] blk_type_o,
  input wire [2:0] reserved_bits_o,
  input wire [8:0] body_size_o,
  input wire busy_o
);
  reg [7:0] hdr_seen;
  wire d;
  wire s;
  wire sup;
  wire big;
  assign d = blk_done_o;
  assign s = blk_skipped_o;
  assign sup = supported_mask_i[blk_type_o];
  assign big = fft_4k_i && (body_size_o > 9'h157);
  // Header octet 0 is kept from the wire, so field checks do not lean on the parser.
  always @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      hdr_seen <= 8'h00;
    else if (byte_valid_i && (!busy_o || blk_start_i))
      hdr_seen <= byte_data_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_type_range: assert property (d |-> blk_generic_o == (blk_type_o > 4'h4))
    else $error("generic flag disagrees with type");
  a_rsv_any: assert property (d && reserved_bits_o != 3'h0 |-> s != sup)
    else $error("reserved bits changed the skip decision");
  a_rsv_echo: assert property (d |-> reserved_bits_o == hdr_seen[3:1])
    else $error("reserved bits not passed on");
  a_size_msb: assert property (d |-> body_size_o[8] == hdr_seen[0])
    else $error("body size top bit wrong");
  a_done_pulse: assert property (d |=> !d)
    else $error("done longer than one cycle");
  a_done_src: assert property (d |-> $past(byte_valid_i))
    else $error("done without a final octet");
  a_done_idle: assert property (d |-> !busy_o)
    else $error("still busy after the last octet");
  a_size_cap: assert property (d |-> blk_size_err_o == big)
    else $error("size flag wrong");
  a_skip_mask: assert property (d |-> s != sup)
    else $error("skip flag disagrees with mask");
  a_fwd_kept: assert property (fwd_valid_o |-> sup)
    else $error("octet of unsupported block forwarded");
  a_type_echo: assert property (d |-> blk_type_o == hdr_seen[7:4])
    else $error("type field wrong");
  a_fwd_data: assert property (fwd_valid_o |-> fwd_data_o == $past(byte_data_i))
    else $error("forwarded octet wrong");
  c_skip: cover property (d && s);
  c_cap: cover property (blk_size_err_o);
  c_fwd: cover property (fwd_valid_o);
  c_resync: cover property (byte_valid_i && blk_start_i && busy_o);
endmodule
bind pgbs_skipper pgbs_props u_props(.*);

/* File: sim/pgbs_demod_model.sv */
// Purpose: Demodulator model sending one block per call.
// Assumes: Octets go out back to back.
// Notes: A bad check value is sent only on request.
`timescale 1ns/1ps
module pgbs_demod_model
(
  // Clock from the bench
  input wire ref_clk_i,
  // Octet stream towards the skipper
  output reg byte_valid_o = 1'b0,
  output reg [7:0] byte_data_o = 8'h00,
  output reg blk_start_o = 1'b0
);
  reg [23:0] c;
  reg [7:0] b;
  integer i, k;
  task send(input [3:0] t, input [2:0] r, input [8:0] n, input bad, input sy);
    begin
      c = 24'h000000;
      for (i = 0; i < n + 5; i = i + 1)
      begin
        b = i == 0 ? {t, r, n[8]} : i == 1 ? n[7:0] : i[7:0];
        if (i >= n + 2)
          b = c[39 - 8 * (i - n) -: 8] ^ {7'h00, bad};
        for (k = 7; k >= 0 && i < n + 2; k = k - 1)
          c = {c[22:0], 1'b0} ^ (c[23] ^ b[k] ? 24'h864CFB : 24'h000000);
        @(posedge ref_clk_i);
        byte_valid_o <= 1'b1;
        byte_data_o <= b;
        blk_start_o <= sy && i == 0;
      end
      @(posedge ref_clk_i);
      byte_valid_o <= 1'b0;
      byte_data_o <= ~b; // Inverted so a stale octet never looks current.
      blk_start_o <= 1'b0;
    end
  endtask
  // Leading octets of a cut block, so the parser is left stranded mid-body.
  task junk(input [3:0] n);
    begin
      for (i = 0; i < n; i = i + 1)
      begin
        @(posedge ref_clk_i);
        byte_valid_o <= 1'b1;
        byte_data_o <= 8'hFF;
      end
      @(posedge ref_clk_i);
      byte_valid_o <= 1'b0;
      byte_data_o <= 8'h00;
    end
  endtask
endmodule

/* File: sim/pgbs_skipper_test.sv */
// Purpose: Self-checking bench for the skipper.
// Assumes: Types 8 to 15 are supported.
// Notes: Every wait is bounded.
`timescale 1ns/1ps
module pgbs_skipper_test;
  reg ck = 1'b0, rst = 1'b1, f4 = 1'b0;
  wire v, dn, sy;
  wire [7:0] d;
  wire [19:0] st;
  integer n_mismatch = 0, checks_done = 0, k, t;
  pgbs_demod_model m(.ref_clk_i(ck), .byte_valid_o(v), .byte_data_o(d), .blk_start_o(sy));
  pgbs_skipper u_dut(.ref_clk_i(ck), .rst_i(rst), .byte_valid_i(v), .byte_data_i(d),
    .blk_start_i(sy), .fft_4k_i(f4), .supported_mask_i(16'hFF00), .fwd_valid_o(),
    .fwd_data_o(), .blk_done_o(dn), .blk_generic_o(st[19]), .blk_skipped_o(st[18]),
    .blk_crc_ok_o(st[17]), .blk_size_err_o(st[16]), .blk_type_o(st[15:12]),
    .reserved_bits_o(st[11:9]), .body_size_o(st[8:0]), .busy_o());
  always #2.5 ck = ~ck;
  task chk(input [19:0] a, input [19:0] x);
    begin
      checks_done = checks_done + 1;
      n_mismatch = n_mismatch + (a !== x);
      if (a !== x)
        $display("[ERR] %0t %h %h", $time, a, x);
    end
  endtask
  task end_of_test;
    begin
      if (n_mismatch == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task run(input [3:0] y, input [2:0] r, input [8:0] n, input bad, input f, input sync);
    begin
      @(posedge ck);
      f4 <= f;
      m.send(y, r, n, bad, sync);
      @(negedge ck);
      for (k = 0; dn !== 1'b1 && k < 20; k = k + 1)
        @(negedge ck);
      n_mismatch = n_mismatch + (k == 20);
      if (k == 20)
        end_of_test;
      chk(st[19:16], {y > 4, y < 8, !bad, f && n > 343});
      chk(st[15:0], {y, r, n});
    end
  endtask
  task s_types;
    for (t = 0; t < 16; t = t + 1)
      run(t[3:0], t[2:0], 9'h003, 1'b0, 1'b0, 1'b0);
  endtask
  task s_crc_zero;
    run(4'h9, 3'h7, 9'h000, 1'b1, 1'b0, 1'b0);
  endtask
  task s_sizes;
    begin
      run(4'h8, 3'h0, 9'h157, 1'b0, 1'b1, 1'b0);
      run(4'h8, 3'h1, 9'h158, 1'b0, 1'b1, 1'b0);
      run(4'hF, 3'h5, 9'h1FF, 1'b0, 1'b0, 1'b0);
    end
  endtask
  // The strobe on the next header must pull the parser out of a cut block.
  task s_resync;
    begin
      m.junk(4'h2);
      run(4'hA, 3'h2, 9'h004, 1'b0, 1'b0, 1'b1);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge ck);
    rst <= 1'b0;
    s_types;
    s_crc_zero;
    s_sizes;
    s_resync;
    end_of_test;
  end
endmodule
